// >>> core/tmc_buf_mem.sv
/*
 * tmc_buf_mem: byte buffer between rf receiver and host, registered read data.
 * assumes: single clock, one write and one read port, caller handles arbitration.
 */
`timescale 1ns/100ps
module tmc_buf_mem (
	// clock
	input  wire logic                      i_clk,
	input  wire logic                      i_ce,
	// write port
	input  wire logic                      i_we,
	input  wire logic [tmc_pkg::BUF_AW-1:0] i_waddr,
	input  wire logic [7:0]                i_wdata,
	// read port
	input  wire logic [tmc_pkg::BUF_AW-1:0] i_raddr,
	output logic      [7:0]                o_rdata
);
	import tmc_pkg::*;

	logic [7:0] mem_q [BUF_DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			o_rdata <= mem_q[i_raddr];
		end
	end
endmodule

// >>> core/tmc_mode_router.sv
/*
 * tmc_mode_router: mode configuration register, mode decode and rf command routing
 * with the tunnel buffer.
 * assumes: the rf frontend supplies received bytes already crc/parity checked and
 * anticollision is handled upstream; host serial logic runs on the same clock.
 */
// Overview of operation
// [R1] keep-crc stores crc, caps message at 30
// [R2] host always accesses mode byte; rf if permitted
// [R3] rf permission low blocks last two blocks
// [R4] bit6 tunnel, bit5 mailbox, none standalone
// [R5] mode enables volatile, nv default, host writable
// [R6] tunnel wins over mailbox
// [R7] mode change anytime, same anticollision
// [R8] standalone routes rf commands to eeprom
// [R9] tunnel blocks eeprom, buffers selected data
// [R10] tunnel rx error raises interrupt
// [R11] host answers each frame with ack/nak
// [R12] host eeprom access kept in tunnel
// [R13] host fills buffer, transmit sends it
// [R14] host handles sleep request itself
// [R15] auth-set allows rf auth changes after auth
// [R16] password change allowed when authenticated
// [R17] flip bit inverts cl2 select bit6
// [R18] power field selects modes 0 to 3
// [R19] bit4 selects nak error handling
// [R20] mask defaults loaded, same access as mode
// [R21] host may answer read with data
// [R22] keep-crc is bit7 of previous byte
// [R23] nv mode copied before any rf command
`timescale 1ns/100ps
module tmc_mode_router (
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_resetn,
	input  wire logic                      i_ce,
	// nonvolatile defaults
	input  wire logic [7:0]                i_nv_mode_cfg,
	input  wire logic [7:0]                i_nv_mask0,
	input  wire logic [7:0]                i_nv_mask1,
	input  wire logic [7:0]                i_nv_rx_cfg,
	input  wire logic                      i_nv_valid,
	// host configuration port
	input  wire logic                      i_host_cfg_we,
	input  wire logic [1:0]                i_host_cfg_idx,
	input  wire logic [7:0]                i_host_cfg_wdata,
	output logic      [7:0]                o_host_cfg_rdata,
	// rf configuration port
	input  wire logic                      i_rf_cfg_we,
	input  wire logic                      i_rf_cfg_re,
	input  wire logic [1:0]                i_rf_cfg_idx,
	input  wire logic [7:0]                i_rf_cfg_wdata,
	output logic      [7:0]                o_rf_cfg_rdata,
	output logic                           o_rf_cfg_denied,
	// rf eeprom write request
	input  wire logic                      i_rf_ee_we,
	input  wire logic [7:0]                i_rf_ee_block,
	input  wire logic                      i_rf_auth_ok,
	input  wire logic                      i_rf_is_auth_cfg,
	input  wire logic                      i_rf_is_password,
	output logic                           o_rf_ee_grant,
	// rf receive stream
	input  wire logic                      i_selected,
	input  wire logic                      i_rx_valid,
	input  wire logic [7:0]                i_rx_data,
	input  wire logic                      i_rx_is_crc,
	input  wire logic                      i_rx_end,
	input  wire logic                      i_rx_err,
	output logic                           o_cmd_to_eeprom,
	output logic                           o_rx_irq,
	output logic                           o_rx_done,
	output logic      [5:0]                o_rx_len,
	// host buffer and transmit
	input  wire logic                      i_host_buf_we,
	input  wire logic [tmc_pkg::BUF_AW-1:0] i_host_buf_addr,
	input  wire logic [7:0]                i_host_buf_wdata,
	output logic      [7:0]                o_host_buf_rdata,
	input  wire logic                      i_host_tx_cmd,
	input  wire logic [5:0]                i_host_tx_len,
	input  wire logic                      i_tx_ready,
	output logic                           o_tx_valid,
	output logic      [7:0]                o_tx_data,
	output logic                           o_tx_last,
	// decoded configuration
	input  wire logic [7:0]                i_selr_cfg,
	output logic      [7:0]                o_sel_res_cl2,
	output tmc_pkg::tmc_mode_e             o_mode,
	output logic                           o_nak_on_err,
	output logic      [1:0]                o_power_mode,
	output logic      [7:0]                o_irq_mask0,
	output logic      [7:0]                o_irq_mask1,
	output logic                           o_ready
);
	import tmc_pkg::*;

	logic [7:0]        cfg_q, mask0_q, mask1_q, rxcfg_q;
	tmc_state_e        st_q;
	logic [5:0]        wptr_q, tx_cnt_q, tx_len_q;
	logic              tx_rd_pend_q;
	logic [BUF_AW-1:0] mem_waddr, mem_raddr;
	logic [7:0]        mem_wdata, mem_rdata;
	logic              mem_we;
	logic              running, rf_cfg_ok, tunnel_rx, rx_take, host_wr_ok;
	logic [5:0]        max_len;

	function automatic tmc_mode_e decode_mode(input logic [7:0] c);
		if (c[BIT_TUNNEL])
			return TMC_TUNNEL; // R6
		else if (c[BIT_MAILBOX])
			return TMC_MAILBOX;
		else
			return TMC_STANDALONE; // R4
	endfunction

	function automatic logic [7:0] sel_byte(input logic [1:0] idx, input logic [7:0] c,
	                                        input logic [7:0] m0, input logic [7:0] m1);
		case (idx)
			IDX_MODE:  return c;
			IDX_MASK0: return m0;
			IDX_MASK1: return m1;
			default:   return 8'h00;
		endcase
	endfunction

	assign running    = (st_q != TMC_ST_INIT);
	assign rf_cfg_ok  = cfg_q[BIT_RFCFG] && running;
	assign tunnel_rx  = running && (decode_mode(cfg_q) == TMC_TUNNEL) && i_selected;
	assign max_len    = rxcfg_q[BIT_KEEP_CRC] ? MAX_LEN_CRC : MAX_LEN_NOCRC; // R1 R22
	// crc bytes are still checked upstream; only their storage depends on keep-crc
	assign rx_take    = tunnel_rx && i_rx_valid && (wptr_q < max_len)
	                    && (!i_rx_is_crc || rxcfg_q[BIT_KEEP_CRC]); // R1 R9
	// host writes lose to an rf byte landing in the same cycle
	assign host_wr_ok = i_host_buf_we && !rx_take && (st_q != TMC_ST_TX);
	assign mem_we     = rx_take || host_wr_ok;
	assign mem_waddr  = rx_take ? wptr_q[BUF_AW-1:0] : i_host_buf_addr;
	assign mem_wdata  = rx_take ? i_rx_data : i_host_buf_wdata;
	assign mem_raddr  = (st_q == TMC_ST_TX) ? tx_cnt_q[BUF_AW-1:0] : i_host_buf_addr;

	tmc_buf_mem u_buf (
		.i_clk   (i_clk),
		.i_ce    (i_ce),
		.i_we    (mem_we),
		.i_waddr (mem_waddr),
		.i_wdata (mem_wdata),
		.i_raddr (mem_raddr),
		.o_rdata (mem_rdata)
	);

	// configuration registers; host has priority over a same-cycle rf write
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_q   <= CFG_NV_DEFAULT;
			mask0_q <= 8'h00;
			mask1_q <= 8'h00;
			rxcfg_q <= 8'h00;
		end else if (i_ce) begin
			if (st_q == TMC_ST_INIT) begin
				if (i_nv_valid) begin
					cfg_q   <= i_nv_mode_cfg; // R23 R5
					mask0_q <= i_nv_mask0; // R20
					mask1_q <= i_nv_mask1; // R20
					rxcfg_q <= i_nv_rx_cfg;
				end
			end else if (i_host_cfg_we) begin
				// mode change accepted at any time once out of init R7 R5 R2
				case (i_host_cfg_idx)
					IDX_MODE:  cfg_q   <= i_host_cfg_wdata;
					IDX_MASK0: mask0_q <= i_host_cfg_wdata;
					IDX_MASK1: mask1_q <= i_host_cfg_wdata;
					default:   rxcfg_q <= i_host_cfg_wdata;
				endcase
			end else if (i_rf_cfg_we && rf_cfg_ok) begin
				case (i_rf_cfg_idx)
					IDX_MODE:  cfg_q   <= i_rf_cfg_wdata; // R2
					IDX_MASK0: mask0_q <= i_rf_cfg_wdata; // R20
					IDX_MASK1: mask1_q <= i_rf_cfg_wdata; // R20
					default:   rxcfg_q <= i_rf_cfg_wdata;
				endcase
			end
		end
	end

	// init state and host transmit sequencing
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q         <= TMC_ST_INIT;
			tx_cnt_q     <= 6'h00;
			tx_len_q     <= 6'h00;
			tx_rd_pend_q <= 1'b0;
			o_tx_valid   <= 1'b0;
			o_tx_data    <= 8'h00;
			o_tx_last    <= 1'b0;
		end else if (i_ce) begin
			case (st_q)
				TMC_ST_INIT: begin
					if (i_nv_valid)
						st_q <= TMC_ST_RUN; // R23
				end
				TMC_ST_RUN: begin
					if (i_host_tx_cmd && i_host_tx_len != 6'h00) begin
						st_q         <= TMC_ST_TX; // R13
						tx_len_q     <= i_host_tx_len;
						tx_cnt_q     <= 6'h00;
						tx_rd_pend_q <= 1'b1;
					end
				end
				TMC_ST_TX: begin
					if (tx_rd_pend_q) begin
						tx_rd_pend_q <= 1'b0;
					end else if (!o_tx_valid) begin
						o_tx_valid <= 1'b1; // R13
						o_tx_data  <= mem_rdata;
						o_tx_last  <= (tx_cnt_q + 6'h01 == tx_len_q);
					end else if (i_tx_ready) begin
						o_tx_valid <= 1'b0;
						o_tx_last  <= 1'b0;
						if (o_tx_last) begin
							st_q <= TMC_ST_RUN;
						end else begin
							tx_cnt_q     <= tx_cnt_q + 6'h01;
							tx_rd_pend_q <= 1'b1;
						end
					end
				end
				default: st_q <= TMC_ST_INIT;
			endcase
		end
	end

	// tunnel receive pointer and events
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wptr_q    <= 6'h00;
			o_rx_irq  <= 1'b0;
			o_rx_done <= 1'b0;
			o_rx_len  <= 6'h00;
		end else if (i_ce) begin
			o_rx_irq  <= tunnel_rx && i_rx_err; // R10
			o_rx_done <= tunnel_rx && i_rx_end;
			if (tunnel_rx && i_rx_end) begin
				o_rx_len <= rx_take ? wptr_q + 6'h01 : wptr_q;
				wptr_q   <= 6'h00;
			end else if (rx_take) begin
				wptr_q <= wptr_q + 6'h01; // R9
			end
		end
	end

	// routing, permissions and decoded outputs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cmd_to_eeprom  <= 1'b0;
			o_rf_ee_grant    <= 1'b0;
			o_rf_cfg_denied  <= 1'b0;
			o_rf_cfg_rdata   <= 8'h00;
			o_host_cfg_rdata <= 8'h00;
			o_host_buf_rdata <= 8'h00;
			o_sel_res_cl2    <= 8'h00;
			o_mode           <= TMC_STANDALONE;
			o_nak_on_err     <= 1'b0;
			o_power_mode     <= 2'b00;
			o_irq_mask0      <= 8'h00;
			o_irq_mask1      <= 8'h00;
			o_ready          <= 1'b0;
		end else if (i_ce) begin
			o_ready          <= running;
			o_mode           <= decode_mode(cfg_q); // R4 R6
			// eeprom serves rf commands except while selected in tunneling; rf writes are never granted in tunneling; host access untouched R8 R12
			o_cmd_to_eeprom  <= running && (decode_mode(cfg_q) != TMC_TUNNEL || !i_selected);
			o_rf_ee_grant    <= running && (decode_mode(cfg_q) != TMC_TUNNEL) && i_rf_ee_we
			                    && ((i_rf_ee_block < LAST_BLOCK - 8'h01) || cfg_q[BIT_RFCFG]) // R3
			                    && (!i_rf_is_auth_cfg || (cfg_q[BIT_AUTH_SET] && i_rf_auth_ok)) // R15
			                    && (!i_rf_is_password || i_rf_auth_ok); // R16
			o_rf_cfg_denied  <= (i_rf_cfg_we || i_rf_cfg_re) && !rf_cfg_ok; // R2
			o_rf_cfg_rdata   <= rf_cfg_ok ? sel_byte(i_rf_cfg_idx, cfg_q, mask0_q, mask1_q)
			                              : 8'h00;
			o_host_cfg_rdata <= (i_host_cfg_idx == 2'h3) ? rxcfg_q
			                  : sel_byte(i_host_cfg_idx, cfg_q, mask0_q, mask1_q);
			o_host_buf_rdata <= mem_rdata;
			o_sel_res_cl2    <= i_selr_cfg ^ ({7'h00, cfg_q[BIT_SEL_FLIP]} << SELR_FLIP_BIT); // R17
			o_nak_on_err     <= cfg_q[BIT_NAK_ERR]; // R19
			o_power_mode     <= {cfg_q[BIT_PWR_HI], cfg_q[BIT_PWR_LO]}; // R18
			o_irq_mask0      <= mask0_q; // R20
			o_irq_mask1      <= mask1_q;
		end
	end

	// checks
	AST_TUNNEL_PRIORITY: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
		i_ce && running && cfg_q[BIT_TUNNEL] |=> o_mode == TMC_TUNNEL || !$past(i_ce, 1))
		else $error("tunnel mode did not win");
	AST_STANDALONE: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
		i_ce && running && cfg_q[BIT_TUNNEL:BIT_MAILBOX] == 2'b00
		|=> o_mode == TMC_STANDALONE)
		else $error("standalone not decoded");
	AST_RF_CFG_BLOCK: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
		i_ce && running && !cfg_q[BIT_RFCFG] && i_rf_cfg_we && !i_host_cfg_we
		|=> $stable(cfg_q) && $stable(mask0_q) && $stable(mask1_q))
		else $error("rf changed configuration without permission");
	AST_LAST_BLOCKS: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
		i_ce && !cfg_q[BIT_RFCFG] && i_rf_ee_block >= LAST_BLOCK - 8'h01 |=> !o_rf_ee_grant)
		else $error("protected block granted");
	AST_TUNNEL_NO_EE: assert property (@(posedge i_clk) disable iff (!i_resetn) // R9
		i_ce && tunnel_rx |=> !o_cmd_to_eeprom)
		else $error("eeprom reached in tunnel mode");
	AST_RX_IRQ: assert property (@(posedge i_clk) disable iff (!i_resetn) // R10
		i_ce && tunnel_rx && i_rx_err |=> o_rx_irq)
		else $error("rx error not signalled");
	AST_CRC_CAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
		rxcfg_q[BIT_KEEP_CRC] |-> wptr_q <= MAX_LEN_CRC)
		else $error("message exceeded limit with crc kept");
	AST_SEL_FLIP: assert property (@(posedge i_clk) disable iff (!i_resetn) // R17
		i_ce ##1 i_ce |-> o_sel_res_cl2[SELR_FLIP_BIT]
		== ($past(i_selr_cfg[SELR_FLIP_BIT]) ^ $past(cfg_q[BIT_SEL_FLIP])))
		else $error("select bit6 wrong");
	AST_INIT_LOAD: assert property (@(posedge i_clk) disable iff (!i_resetn) // R23
		i_ce && st_q == TMC_ST_INIT && i_nv_valid |=> cfg_q == $past(i_nv_mode_cfg))
		else $error("nv mode not loaded");
	AST_POWER: assert property (@(posedge i_clk) disable iff (!i_resetn) // R18
		i_ce |=> o_power_mode == $past(cfg_q[BIT_PWR_HI:BIT_PWR_LO]) || !$past(i_ce, 1))
		else $error("power mode mismatch");

	COV_TUNNEL_RX: cover property (@(posedge i_clk) disable iff (!i_resetn)
		rx_take ##[1:40] i_rx_end && tunnel_rx);
	COV_TX_DONE: cover property (@(posedge i_clk) disable iff (!i_resetn)
		o_tx_valid && o_tx_last && i_tx_ready);
	COV_MODE_SWITCH: cover property (@(posedge i_clk) disable iff (!i_resetn)
		o_mode == TMC_STANDALONE ##[1:20] o_mode == TMC_TUNNEL);
endmodule

// >>> core/tmc_pkg.sv
/*
 * tmc_pkg: constants for the communication-mode configuration and tunnel router.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package tmc_pkg;
	// mode configuration byte layout, plus keep-crc bit of the rx byte and flip bit of the select byte
	localparam int          CFG_W          = 8;
	localparam int          BIT_RFCFG      = 7;
	localparam int          BIT_TUNNEL     = 6;
	localparam int          BIT_MAILBOX    = 5;
	localparam int          BIT_NAK_ERR    = 4;
	localparam int          BIT_AUTH_SET   = 3;
	localparam int          BIT_SEL_FLIP   = 2;
	localparam int          BIT_PWR_HI     = 1;
	localparam int          BIT_PWR_LO     = 0;
	localparam int          BIT_KEEP_CRC   = 7;
	localparam int          SELR_FLIP_BIT  = 6;
	localparam logic [7:0]  CFG_NV_DEFAULT = 8'h80;
	// buffer geometry
	localparam int          BUF_DEPTH      = 32;
	localparam int          BUF_AW         = 5;
	localparam int          CRC_BYTES      = 2;
	localparam logic [5:0]  MAX_LEN_CRC    = 6'h1e;
	localparam logic [5:0]  MAX_LEN_NOCRC  = 6'h20;
	// configuration block indices reachable from either side
	localparam logic [1:0]  IDX_MODE       = 2'h0;
	localparam logic [1:0]  IDX_MASK0      = 2'h1;
	localparam logic [1:0]  IDX_MASK1      = 2'h2;
	// index of the last eeprom block; the last two are protected from rf while the rf permission bit is low
	localparam logic [7:0]  LAST_BLOCK     = 8'h0f;

	typedef enum logic [1:0] {
		TMC_STANDALONE = 2'b00,
		TMC_MAILBOX    = 2'b01,
		TMC_TUNNEL     = 2'b10
	} tmc_mode_e;

	typedef enum logic [1:0] {
		TMC_ST_INIT = 2'b00,
		TMC_ST_RUN  = 2'b01,
		TMC_ST_TX   = 2'b10
	} tmc_state_e;
endpackage

// >>> sim/tb_tag_mode_config_tunnel.sv
/*
 * tb_tag_mode_config_tunnel: self-checking bench for the mode router.
 * assumes: tmc_pkg and tmc_mode_router compiled first, rf reader model alongside.
 */
`timescale 1ns/100ps
module tb_tag_mode_config_tunnel;
	import tmc_pkg::*;
	logic i_clk = 0, i_resetn = 0, i_ce = 1, i_nv_valid = 0;
	logic [7:0] i_nv_mode_cfg = 8'h40, i_nv_mask0 = 8'h5a, i_nv_mask1 = 8'ha5, i_nv_rx_cfg = 0;
	logic i_host_cfg_we = 0, i_rf_cfg_we = 0, i_rf_cfg_re = 0, i_rf_ee_we = 0;
	logic [1:0] i_host_cfg_idx = 0, i_rf_cfg_idx = 0;
	logic [7:0] i_host_cfg_wdata = 0, i_rf_cfg_wdata = 0, i_rf_ee_block = 0, i_selr_cfg = 8'h55;
	logic i_rf_auth_ok = 0, i_rf_is_auth_cfg = 0, i_rf_is_password = 0, i_host_buf_we = 0;
	logic [4:0] i_host_buf_addr = 0;
	logic [7:0] i_host_buf_wdata = 0;
	logic i_host_tx_cmd = 0;
	logic [5:0] i_host_tx_len = 0;
	wire logic i_selected, i_rx_valid, i_rx_is_crc, i_rx_end, i_rx_err, i_tx_ready;
	wire logic [7:0] i_rx_data;
	logic [7:0] o_host_cfg_rdata, o_rf_cfg_rdata, o_host_buf_rdata, o_tx_data, o_sel_res_cl2;
	logic [7:0] o_irq_mask0, o_irq_mask1;
	logic o_rf_cfg_denied, o_rf_ee_grant, o_cmd_to_eeprom, o_rx_irq, o_rx_done;
	logic o_tx_valid, o_tx_last, o_nak_on_err, o_ready;
	logic [5:0] o_rx_len;
	logic [1:0] o_power_mode;
	tmc_mode_e o_mode;
	int fails = 0, n_checks = 0;

	tmc_mode_router i_dut (.i_clk, .i_resetn, .i_ce, .i_nv_mode_cfg, .i_nv_mask0, .i_nv_mask1,
		.i_nv_rx_cfg, .i_nv_valid, .i_host_cfg_we, .i_host_cfg_idx, .i_host_cfg_wdata,
		.o_host_cfg_rdata, .i_rf_cfg_we, .i_rf_cfg_re, .i_rf_cfg_idx, .i_rf_cfg_wdata,
		.o_rf_cfg_rdata, .o_rf_cfg_denied, .i_rf_ee_we, .i_rf_ee_block, .i_rf_auth_ok,
		.i_rf_is_auth_cfg, .i_rf_is_password, .o_rf_ee_grant, .i_selected, .i_rx_valid,
		.i_rx_data, .i_rx_is_crc, .i_rx_end, .i_rx_err, .o_cmd_to_eeprom, .o_rx_irq, .o_rx_done,
		.o_rx_len, .i_host_buf_we, .i_host_buf_addr, .i_host_buf_wdata, .o_host_buf_rdata,
		.i_host_tx_cmd, .i_host_tx_len, .i_tx_ready, .o_tx_valid, .o_tx_data, .o_tx_last,
		.i_selr_cfg, .o_sel_res_cl2, .o_mode, .o_nak_on_err, .o_power_mode, .o_irq_mask0,
		.o_irq_mask1, .o_ready);
	tmc_rf_reader i_rdr (.i_clk(i_clk), .o_selected(i_selected), .o_rx_valid(i_rx_valid),
		.o_rx_data(i_rx_data), .o_rx_is_crc(i_rx_is_crc), .o_rx_end(i_rx_end),
		.o_rx_err(i_rx_err), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
		.i_tx_last(o_tx_last), .o_tx_ready(i_tx_ready));

	always #5 i_clk = ~i_clk;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic step();
		@(posedge i_clk);
		#1;
	endtask
	task automatic hw(input logic [1:0] idx, input logic [7:0] d);
		i_host_cfg_idx = idx;
		i_host_cfg_wdata = d;
		i_host_cfg_we = 1;
		step();
		i_host_cfg_we = 0;
		step();
	endtask
	task automatic rw(input logic we, input logic [7:0] d, input logic den, input logic [7:0] rd);
		i_rf_cfg_idx = 2'h1;
		i_rf_cfg_wdata = d;
		i_rf_cfg_we = we;
		i_rf_cfg_re = !we;
		step();
		chk("rf_denied", {7'h0, den}, {7'h0, o_rf_cfg_denied});
		i_rf_cfg_we = 0;
		i_rf_cfg_re = 0;
		step();
		if (!we)
			chk("rf_rdata", rd, o_rf_cfg_rdata);
	endtask
	task automatic ee(input logic [7:0] b, input logic au, ac, pw, input logic exp_g);
		i_rf_ee_block = b;
		i_rf_auth_ok = au;
		i_rf_is_auth_cfg = ac;
		i_rf_is_password = pw;
		i_rf_ee_we = 1;
		step();
		chk("ee_grant", {7'h0, exp_g}, {7'h0, o_rf_ee_grant});
		i_rf_ee_we = 0;
		step();
	endtask
	task automatic t_init();
		chk("ready_early", 8'h0, {7'h0, o_ready});
		i_nv_valid = 1;
		for (int k = 0; k < 20 && o_ready !== 1'b1; k++)
			step();
		chk("mode_nv", {6'h0, TMC_TUNNEL}, {6'h0, o_mode});
		chk("mask0_nv", 8'h5a, o_irq_mask0);
		chk("mask1_nv", 8'ha5, o_irq_mask1);
		i_host_cfg_idx = IDX_MODE;
		step();
		step();
		chk("mode_byte", 8'h40, o_host_cfg_rdata);
		$display("test init done");
	endtask
	task automatic t_decode();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = 8'h80 | 8'(i << 5) | 8'(i[0] << 4) | 8'(i);
			hw(IDX_MODE, v);
			chk("mode", (i == 0) ? 8'h0 : (i == 1) ? 8'h1 : 8'h2, {6'h0, o_mode});
			chk("power", 8'(i), {6'h0, o_power_mode});
			chk("nak", 8'(i[0]), {7'h0, o_nak_on_err});
			if (i != 1)
				chk("to_ee", 8'(i == 0), {7'h0, o_cmd_to_eeprom});
		end
		$display("test decode done");
	endtask
	task automatic t_perm();
		hw(IDX_MODE, 8'h00);
		rw(1, 8'h33, 1, 0);
		rw(0, 8'h0, 1, 8'h0);
		chk("mask0_kept", 8'h5a, o_irq_mask0);
		ee(8'h0f, 0, 0, 0, 0);
		ee(8'h0e, 0, 0, 0, 0);
		ee(8'h0d, 0, 0, 0, 1);
		hw(IDX_MODE, 8'h80);
		rw(1, 8'h33, 0, 0);
		rw(0, 8'h0, 0, 8'h33);
		ee(8'h0f, 0, 0, 0, 1);
		ee(8'h05, 1, 1, 0, 0);
		ee(8'h05, 1, 0, 1, 1);
		hw(IDX_MODE, 8'h88);
		ee(8'h05, 0, 1, 0, 0);
		ee(8'h05, 1, 1, 0, 1);
		hw(IDX_MODE, 8'h80);
		chk("selr", 8'h55, o_sel_res_cl2);
		hw(IDX_MODE, 8'h84);
		chk("selr_flip", 8'h15, o_sel_res_cl2);
		// with the clock enable low a host write must not land
		i_ce = 0;
		hw(IDX_MODE, 8'h83);
		chk("ce_power", 8'h0, {6'h0, o_power_mode});
		i_ce = 1;
		step();
		chk("ce_mode_byte", 8'h84, o_host_cfg_rdata);
		$display("test permission done");
	endtask
	task automatic frame(input int n, input logic [7:0] len, input logic err);
		logic irq;
		irq = 0;
		fork
			i_rdr.send(n, 2, err);
			for (int k = 0; k < 60 && o_rx_done !== 1'b1; k++) begin
				step();
				irq |= (o_rx_irq === 1'b1);
			end
		join
		chk("rx_len", len, {2'h0, o_rx_len});
		chk("rx_irq", {7'h0, err}, {7'h0, irq});
	endtask
	task automatic t_tunnel();
		hw(2'h3, 8'h80);
		hw(IDX_MODE, 8'hc0);
		chk("to_ee", 8'h0, {7'h0, o_cmd_to_eeprom});
		// outside the selected state rf commands still reach the eeprom
		i_rdr.o_selected = 1'b0;
		step();
		step();
		chk("to_ee_unsel", 8'h1, {7'h0, o_cmd_to_eeprom});
		i_rdr.o_selected = 1'b1;
		step();
		ee(8'h05, 0, 0, 0, 0);
		frame(28, 8'd30, 1);
		i_host_buf_addr = 5'd29;
		step();
		step();
		step();
		chk("buf_crc", 8'hbd, o_host_buf_rdata);
		// the host reads the first forwarded command byte back from the buffer
		i_host_buf_addr = 5'd0;
		step();
		step();
		step();
		chk("buf_first", 8'ha0, o_host_buf_rdata);
		hw(2'h3, 8'h00);
		frame(40, 8'd32, 0);
		$display("test tunnel done");
	endtask
	task automatic t_tx();
		for (int k = 0; k < 3; k++) begin
			i_host_buf_we = 1;
			i_host_buf_addr = 5'(k);
			i_host_buf_wdata = 8'h31 + 8'(k);
			step();
		end
		i_host_buf_we = 0;
		i_host_tx_len = 6'd3;
		// host answers the received frame with data of its own
		i_host_tx_cmd = 1;
		i_rdr.tx_en = 1;
		step();
		i_host_tx_cmd = 0;
		for (int k = 0; k < 40 && i_rdr.got_q.size() < 3; k++)
			step();
		i_rdr.tx_en = 0;
		chk("tx_count", 8'd3, 8'(i_rdr.got_q.size()));
		for (int k = 0; k < i_rdr.got_q.size(); k++)
			chk("tx_byte", 8'h31 + 8'(k), i_rdr.got_q[k]);
		chk("tx_last", 8'd3, 8'(i_rdr.last_at));
		$display("test transmit done");
	endtask

	initial begin
		repeat (5000) @(posedge i_clk);
		fails++;
		$display("watchdog expired");
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge i_clk);
		#1;
		i_resetn = 1;
		step();
		t_init();
		t_decode();
		t_perm();
		t_tunnel();
		t_tx();
		wrap_up();
	end
endmodule

// >>> sim/tmc_rf_reader.sv
/*
 * tmc_rf_reader: behavioural rf reader feeding the receive stream, taking tx bytes.
 * assumes: same clock as the router; the testbench calls send and sets tx_en.
 */
`timescale 1ns/100ps
module tmc_rf_reader (
	// clock
	input  wire logic       i_clk,
	// receive stream toward the tag
	output logic            o_selected,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_data,
	output logic            o_rx_is_crc,
	output logic            o_rx_end,
	output logic            o_rx_err,
	// transmit stream from the tag
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_last,
	output logic            o_tx_ready
);
	logic [7:0] got_q[$];
	int         last_at = 0;
	logic       tx_en = 1'b0;
	initial begin
		o_selected = 1'b1;
		o_rx_valid = 1'b0;
		o_rx_data = 8'h5c;
		o_rx_is_crc = 1'b0;
		o_rx_end = 1'b0;
		o_rx_err = 1'b0;
		o_tx_ready = 1'b0;
	end
	// slow reader: ready only every other cycle, so the tag must hold each byte
	always @(posedge i_clk) begin
		if (i_tx_valid === 1'b1 && o_tx_ready) begin
			got_q.push_back(i_tx_data);
			if (i_tx_last === 1'b1)
				last_at = got_q.size();
		end
		o_tx_ready <= #1 tx_en && !o_tx_ready;
	end
	task automatic send(input int n, input int ncrc, input bit err);
		for (int k = 0; k < n + ncrc; k++) begin
			@(posedge i_clk);
			#1;
			o_rx_valid = 1'b1;
			o_rx_data = 8'ha0 + 8'(k);
			o_rx_is_crc = (k >= n);
		end
		@(posedge i_clk);
		#1;
		// released data line shows no stale byte
		o_rx_valid = 1'b0;
		o_rx_data = ~o_rx_data;
		o_rx_is_crc = 1'b0;
		o_rx_end = 1'b1;
		o_rx_err = err;
		@(posedge i_clk);
		#1;
		o_rx_end = 1'b0;
		o_rx_err = 1'b0;
		o_rx_data = ~o_rx_data;
	endtask
endmodule
